/* File: core/wpt_pkg.sv */
// shared constants and carriers for the wireless power phase controller
package wpt_pkg;
	// 20 MHz system clock
	localparam int CLK_HZ = 20000000;
	// receiver bit rate on the amplitude link, bits per second
	localparam int ASK_BPS = 2000;
	localparam int BIT_CYC = CLK_HZ / ASK_BPS;
	// a half bit is the narrow transition spacing
	localparam int HALF_CYC = BIT_CYC / 2;
	// narrow versus wide transition threshold, three quarters of a bit
	localparam int WIDE_CYC = (BIT_CYC * 3) / 4;
	// gap with no transition that aborts a byte, two bits
	localparam int IDLE_CYC = BIT_CYC * 2;
	localparam int CNT_W = 16;
	// ping period in milliseconds and in cycles
	localparam int PING_MS = 500;
	localparam int PING_CYC = (CLK_HZ / 1000) * PING_MS;
	// time a digital ping waits for signal strength, milliseconds
	localparam int PING_WAIT_MS = 70;
	localparam int PING_WAIT_CYC = (CLK_HZ / 1000) * PING_WAIT_MS;
	// time without a control error or received power packet before power is removed, milliseconds
	localparam int PKT_TMO_MS = 1800;
	localparam int PKT_TMO_CYC = (CLK_HZ / 1000) * PKT_TMO_MS;
	localparam int TMR_W = 26;
	// packet headers
	localparam logic [7:0] HDR_SIG = 8'h01;
	localparam logic [7:0] HDR_EPT = 8'h02;
	localparam logic [7:0] HDR_CEP = 8'h03;
	localparam logic [7:0] HDR_RPP = 8'h04;
	localparam logic [7:0] HDR_CFG = 8'h51;
	// pwm duty ratio
	localparam int DUTY_W = 8;
	localparam logic [7:0] DUTY_RST = 8'h40;
	localparam logic [7:0] DUTY_MAX = 8'hff;
	// duty cap when the supply is a 5 V source, baseline 5 W profile
	localparam logic [7:0] DUTY_BPP_MAX = 8'h80;
	localparam logic [7:0] DUTY_STEP = 8'h04;
	// fixed operating frequency 127.7 kHz as a carrier period
	localparam int OP_FREQ_HZ = 127700;
	localparam int OP_CYC = CLK_HZ / OP_FREQ_HZ;
	localparam int FSK_DELTA = 2;
	// source classes
	localparam logic [2:0] SRC_SDP = 3'h0;
	localparam logic [2:0] SRC_CDP = 3'h1;
	localparam logic [2:0] SRC_DCP = 3'h2;
	localparam logic [2:0] SRC_ADP = 3'h3;

	typedef enum logic [4:0] {
		ST_SELECT = 5'h01,
		ST_PING = 5'h02,
		ST_IDCFG = 5'h04,
		ST_XFER = 5'h08,
		ST_STOP = 5'h10
	} wpt_phase_e;

	// one decoded byte from the amplitude link
	typedef struct packed {
		logic valid;
		logic perr;
		logic [7:0] data;
	} wpt_byte_s;

	// power stage commands
	typedef struct packed {
		logic power_on;
		logic measure;
		logic [7:0] duty;
	} wpt_drive_s;
endpackage

/* File: core/wpt_ask_dec.sv */
// bi-phase bit and byte decoder for the receiver amplitude link
`timescale 1ns/1ns
module wpt_ask_dec (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ask_in,
	output wpt_pkg::wpt_byte_s byte_out
);
	logic ask_d_ff;
	logic [wpt_pkg::CNT_W-1:0] gap_ff;
	logic half_ff;
	logic [3:0] nbit_ff;
	logic [9:0] sh_ff;
	logic busy_ff;
	wpt_pkg::wpt_byte_s out_ff;

	// edge and width classification
	wire edge_w = ask_in ^ ask_d_ff;
	wire wide_w = gap_ff >= wpt_pkg::CNT_W'(wpt_pkg::WIDE_CYC);
	wire idle_w = gap_ff >= wpt_pkg::CNT_W'(wpt_pkg::IDLE_CYC);
	// a zero is a wide gap, a one is the second narrow gap
	wire bit_done_w = edge_w & (wide_w | half_ff);
	wire bit_val_w = ~wide_w;
	// start bit must be zero; frame complete after 11 bits
	wire frame_w = bit_done_w & busy_ff & (nbit_ff == 4'ha);
	// odd parity: data and parity together hold an odd count of ones
	wire par_ok_w = ^sh_ff[9:1];
	wire stop_ok_w = bit_val_w;

	assign byte_out = out_ff;

	// transition timer
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ask_d_ff <= 1'b0;
			gap_ff <= '0;
		end else begin
			ask_d_ff <= ask_in;
			gap_ff <= edge_w ? '0 : (idle_w ? gap_ff : gap_ff + 1'b1);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			half_ff <= 1'b0;
		end else if (edge_w) begin
			half_ff <= ~wide_w & ~half_ff;
		end else if (idle_w) begin
			half_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			nbit_ff <= '0;
			sh_ff <= '0;
			busy_ff <= 1'b0;
			out_ff <= '0;
		end else begin
			out_ff.valid <= 1'b0;
			if (idle_w) begin
				busy_ff <= 1'b0;
			end else if (bit_done_w & ~busy_ff) begin
				// only a zero can start a byte
				busy_ff <= ~bit_val_w;
				nbit_ff <= 4'h1;
			end else if (frame_w) begin
				busy_ff <= 1'b0;
				out_ff.valid <= stop_ok_w;
				out_ff.perr <= ~par_ok_w;
				out_ff.data <= sh_ff[8:1];
			end else if (bit_done_w) begin
				// lsb first into the shifter; nine shifts leave data at
				// bits 8..1 and parity at bit 9
				sh_ff <= {bit_val_w, sh_ff[9:1]};
				nbit_ff <= nbit_ff + 4'h1;
			end
		end
	end
endmodule

/* File: core/wpt_fsk_gen.sv */
// fixed-frequency carrier with frequency shift for replies
`timescale 1ns/1ns
module wpt_fsk_gen (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic run,
	input wire logic shift,
	output logic carrier
);
	logic [7:0] cnt_ff;
	logic car_ff;

	// shifted period is a little longer than the nominal one
	wire [7:0] per_w = shift ? 8'(wpt_pkg::OP_CYC + wpt_pkg::FSK_DELTA)
		: 8'(wpt_pkg::OP_CYC);
	wire half_w = cnt_ff >= {1'b0, per_w[7:1]};

	assign carrier = car_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
			car_ff <= 1'b0;
		end else if (!run) begin
			cnt_ff <= '0;
			car_ff <= 1'b0;
		end else begin
			cnt_ff <= (cnt_ff >= per_w - 8'h01) ? 8'h00 : cnt_ff + 8'h01;
			car_ff <= half_w;
		end
	end
endmodule

/* File: core/wpt_phase_ctrl.sv */
// phase sequencer and power control of the wireless power transmitter
`timescale 1ns/1ns
module wpt_phase_ctrl #(
	parameter int PING_CYC = wpt_pkg::PING_CYC,
	parameter int PING_WAIT_CYC = wpt_pkg::PING_WAIT_CYC,
	parameter int PKT_TMO_CYC = wpt_pkg::PKT_TMO_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ask_in,
	input wire logic object_seen,
	input wire logic fault,
	input wire logic [2:0] src_class,
	input wire logic src_5v_only,
	output logic measure_en,
	output logic power_en,
	output logic carrier,
	output logic pwm_out,
	output logic [4:0] phase,
	output logic bpp_mode,
	output logic [7:0] duty,
	output logic [7:0] rx_byte,
	output logic rx_valid
);
	wpt_pkg::wpt_byte_s rx_w;
	wpt_pkg::wpt_phase_e st_ff;
	wpt_pkg::wpt_phase_e nxt_st;
	logic [wpt_pkg::TMR_W-1:0] tmr_ff;
	logic [wpt_pkg::TMR_W-1:0] nxt_tmr;
	logic hdr_ff;
	logic [7:0] hdr_val_ff;
	logic cfg_ok_ff;
	logic bpp_ff;
	logic [7:0] duty_ff;
	logic [7:0] pwm_cnt_ff;
	logic pwm_ff;
	logic fsk_ff;
	logic [7:0] rxb_ff;
	logic rxv_ff;
	wpt_pkg::wpt_drive_s drv_w;

	// receiver bytes arrive by amplitude keying
	// decoder tracks the fixed receiver bit rate
	wpt_ask_dec u_dec (
		.clock(clock),
		.rst_n(rst_n),
		.ask_in(ask_in),
		.byte_out(rx_w)
	);

	// carrier for the power stage; fsk_ff holds shift low, so no frequency shift replies are sent
	wpt_fsk_gen u_fsk (
		.clock(clock),
		.rst_n(rst_n),
		.run(drv_w.power_on),
		.shift(fsk_ff),
		.carrier(carrier)
	);

	// packet byte decoding: first good byte is header, second is payload
	wire good_w = rx_w.valid & ~rx_w.perr;
	wire pay_w = good_w & hdr_ff;
	wire is_sig_w = pay_w & (hdr_val_ff == wpt_pkg::HDR_SIG);
	wire is_cfg_w = pay_w & (hdr_val_ff == wpt_pkg::HDR_CFG);
	wire is_cep_w = pay_w & (hdr_val_ff == wpt_pkg::HDR_CEP);
	wire is_rpp_w = pay_w & (hdr_val_ff == wpt_pkg::HDR_RPP);
	wire is_ept_w = pay_w & (hdr_val_ff == wpt_pkg::HDR_EPT);
	wire tmr_out_w = tmr_ff == '0;
	wire in_xfer_w = st_ff == wpt_pkg::ST_XFER;
	// control error is a signed byte: positive asks for more power
	wire cep_up_w = is_cep_w & ~rx_w.data[7] & (rx_w.data != 8'h00);
	wire cep_dn_w = is_cep_w & rx_w.data[7];

	// a 5 V source forces the baseline profile
	wire bpp_now_w = src_5v_only | (src_class == wpt_pkg::SRC_SDP)
		| (src_class == wpt_pkg::SRC_CDP);
	wire [7:0] cap_w = bpp_ff ? wpt_pkg::DUTY_BPP_MAX : wpt_pkg::DUTY_MAX;

	// power stage gated by phase, not frequency
	assign drv_w.measure = st_ff == wpt_pkg::ST_SELECT;
	assign drv_w.power_on = (st_ff == wpt_pkg::ST_PING)
		| (st_ff == wpt_pkg::ST_IDCFG) | in_xfer_w;
	assign drv_w.duty = duty_ff;

	assign measure_en = drv_w.measure;
	assign power_en = drv_w.power_on;
	assign pwm_out = pwm_ff;
	assign phase = st_ff;
	assign bpp_mode = bpp_ff;
	assign duty = duty_ff;
	assign rx_byte = rxb_ff;
	assign rx_valid = rxv_ff;

	always_comb begin
		nxt_st = st_ff;
		nxt_tmr = tmr_out_w ? tmr_ff : tmr_ff - 1'b1;
		case (st_ff)
			wpt_pkg::ST_SELECT: begin
				if (object_seen | tmr_out_w) begin
					nxt_st = wpt_pkg::ST_PING;
					nxt_tmr = wpt_pkg::TMR_W'(PING_WAIT_CYC);
				end
			end
			wpt_pkg::ST_PING: begin
				// signal strength accepted, power kept on
				if (is_sig_w) begin
					nxt_st = wpt_pkg::ST_IDCFG;
					nxt_tmr = wpt_pkg::TMR_W'(PKT_TMO_CYC);
				end else if (tmr_out_w) begin
					nxt_st = wpt_pkg::ST_STOP;
				end
			end
			wpt_pkg::ST_IDCFG: begin
				if (cfg_ok_ff) begin
					nxt_st = wpt_pkg::ST_XFER;
					nxt_tmr = wpt_pkg::TMR_W'(PKT_TMO_CYC);
				end else if (tmr_out_w | is_ept_w) begin
					nxt_st = wpt_pkg::ST_STOP;
				end
			end
			wpt_pkg::ST_XFER: begin
				// a control error or received power packet keeps the link alive
				if (is_ept_w | tmr_out_w) begin
					nxt_st = wpt_pkg::ST_STOP;
				end else if (is_cep_w | is_rpp_w) begin
					nxt_tmr = wpt_pkg::TMR_W'(PKT_TMO_CYC);
				end
			end
			wpt_pkg::ST_STOP: begin
				nxt_st = wpt_pkg::ST_SELECT;
				nxt_tmr = wpt_pkg::TMR_W'(PING_CYC);
			end
			default: begin
				nxt_st = wpt_pkg::ST_STOP;
			end
		endcase
		// fault halts power at once
		// only while power is driven, so stop always drains to standby
		if (fault & drv_w.power_on) begin
			nxt_st = wpt_pkg::ST_STOP;
		end
	end

	// phase register and shared timer
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= wpt_pkg::ST_SELECT;
			tmr_ff <= '0;
		end else begin
			st_ff <= nxt_st;
			tmr_ff <= nxt_tmr;
		end
	end

	// header tracking; a byte with a parity error resynchronises to the next header
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hdr_ff <= 1'b0;
			hdr_val_ff <= '0;
			rxb_ff <= '0;
			rxv_ff <= 1'b0;
		end else begin
			rxv_ff <= good_w;
			if (good_w) begin
				rxb_ff <= rx_w.data;
			end
			if (rx_w.valid & rx_w.perr) begin
				hdr_ff <= 1'b0;
			end else if (good_w) begin
				hdr_ff <= ~hdr_ff;
				hdr_val_ff <= hdr_ff ? hdr_val_ff : rx_w.data;
			end
		end
	end

	// baseline transmitter never acknowledges, so fsk stays off
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cfg_ok_ff <= 1'b0;
			bpp_ff <= 1'b1;
			fsk_ff <= 1'b0;
		end else begin
			fsk_ff <= 1'b0;
			if (st_ff != wpt_pkg::ST_IDCFG) begin
				cfg_ok_ff <= 1'b0;
			end else if (is_cfg_w) begin
				cfg_ok_ff <= 1'b1;
			end
			if (st_ff == wpt_pkg::ST_SELECT) begin
				bpp_ff <= bpp_now_w;
			end
		end
	end

	// duty steps with requests, capped by mode
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			duty_ff <= wpt_pkg::DUTY_RST;
		end else if (!in_xfer_w) begin
			duty_ff <= wpt_pkg::DUTY_RST;
		end else if (cep_up_w) begin
			duty_ff <= (duty_ff >= cap_w - wpt_pkg::DUTY_STEP) ? cap_w
				: duty_ff + wpt_pkg::DUTY_STEP;
		end else if (cep_dn_w) begin
			duty_ff <= (duty_ff <= wpt_pkg::DUTY_STEP) ? 8'h00
				: duty_ff - wpt_pkg::DUTY_STEP;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pwm_cnt_ff <= '0;
			pwm_ff <= 1'b0;
		end else begin
			pwm_cnt_ff <= pwm_cnt_ff + 8'h01;
			pwm_ff <= drv_w.power_on & (pwm_cnt_ff < duty_ff);
		end
	end
endmodule

/* File: test/wpt_rx_model.sv */
// receiver model that sends bi-phase amplitude packets
`timescale 1ns/1ns
module wpt_rx_model (
	input wire logic clock,
	output logic ask_out
);
	localparam int HB = wpt_pkg::HALF_CYC;

	// line idles at its last level between packets
	initial ask_out = 1'b0;

	task automatic hold(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic send_bit(input logic b);
		if (b) begin
			hold(HB);
			ask_out = ~ask_out;
		end
		hold(b ? HB : 2 * HB);
		ask_out = ~ask_out;
	endtask

	// start, lsb first, odd parity, stop
	task automatic send_byte(input logic [7:0] d);
		send_bit(1'b0);
		for (int i = 0; i < 8; i++) send_bit(d[i]);
		send_bit(~^d);
		send_bit(1'b1);
	endtask

	// header then payload, never waits for a reply
	task automatic send_pkt(input logic [7:0] h, input logic [7:0] p);
		hold(HB);
		ask_out = ~ask_out;
		send_byte(h);
		send_byte(p);
		hold(4 * HB); // long idle so the next packet starts clean
	endtask
endmodule

/* File: test/wpt_phase_ctrl_sva.sv */
// port assertions of the phase controller
`timescale 1ns/1ns
module wpt_phase_ctrl_sva (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ask_in,
	input wire logic object_seen,
	input wire logic fault,
	input wire logic [2:0] src_class,
	input wire logic src_5v_only,
	input wire logic measure_en,
	input wire logic power_en,
	input wire logic carrier,
	input wire logic pwm_out,
	input wire logic [4:0] phase,
	input wire logic bpp_mode,
	input wire logic [7:0] duty,
	input wire logic [7:0] rx_byte,
	input wire logic rx_valid
);
	logic [8:0] per_ff;
	logic seen_ff;

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	// carrier period count; dropped power forgets the last edge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			per_ff <= 9'h000;
			seen_ff <= 1'b0;
		end else begin
			per_ff <= $rose(carrier) ? 9'h000 : per_ff + 9'h001;
			seen_ff <= power_en & (seen_ff | $rose(carrier));
		end
	end

	sequence s_stop;
		phase == 5'h10;
	endsequence
	sequence s_sel;
		phase == 5'h01;
	endsequence

	chk_measure_sel: assert property (measure_en == (phase == 5'h01))
		else $error("measure enable outside selection");
	chk_power_phase: assert property (power_en ==
		(phase == 5'h02 || phase == 5'h04 || phase == 5'h08))
		else $error("power enable does not match phase");
	chk_ping_entry: assert property ($past(phase) == 5'h01 &&
		phase != 5'h01 |-> phase == 5'h02)
		else $error("selection left for other than ping");
	chk_xfer_entry: assert property (phase == 5'h08 &&
		$past(phase) != 5'h08 |-> $past(phase) == 5'h04)
		else $error("transfer entered without contract");
	chk_fault_stop: assert property (fault && power_en |=>
		s_stop ##1 s_sel)
		else $error("fault did not halt power");
	chk_stop_select: assert property (s_stop |=> s_sel)
		else $error("stop not followed by selection");
	chk_duty_idle: assert property (power_en && phase != 5'h08 |->
		duty == 8'h40)
		else $error("duty moved before transfer");
	chk_duty_step: assert property ($changed(duty) && phase == 5'h08 &&
		$past(phase) == 5'h08 |-> duty == $past(duty) + 8'h04 ||
		duty == $past(duty) - 8'h04 || duty == 8'hff || duty == 8'h00)
		else $error("duty changed by a wrong step");
	chk_bpp_cap: assert property (bpp_mode |-> duty <= 8'h80)
		else $error("duty above baseline cap");
	chk_carrier_per: assert property ($rose(carrier) && seen_ff |->
		per_ff == 9'h09b)
		else $error("carrier period not fixed");
endmodule

bind wpt_phase_ctrl wpt_phase_ctrl_sva chk (.clock, .rst_n, .ask_in,
	.object_seen, .fault, .src_class, .src_5v_only, .measure_en,
	.power_en, .carrier, .pwm_out, .phase, .bpp_mode, .duty, .rx_byte,
	.rx_valid);

/* File: test/wpt_phase_ctrl_tb.sv */
// self-checking testbench of the phase controller
`timescale 1ns/1ns
module wpt_phase_ctrl_tb;
	logic clock, rst_n, ask_in, object_seen, fault, src_5v_only;
	logic [2:0] src_class;
	logic measure_en, power_en, carrier, pwm_out, bpp_mode, rx_valid;
	logic [4:0] phase;
	logic [7:0] duty, rx_byte;
	int fails = 0;
	int n_compared = 0;

	wpt_rx_model rx (.clock(clock), .ask_out(ask_in));

	// ping wait must outlast a whole two-byte packet
	wpt_phase_ctrl #(.PING_CYC(200), .PING_WAIT_CYC(300000),
		.PKT_TMO_CYC(400000)) dut (.clock(clock), .rst_n(rst_n),
		.ask_in(ask_in), .object_seen(object_seen), .fault(fault),
		.src_class(src_class), .src_5v_only(src_5v_only),
		.measure_en(measure_en), .power_en(power_en), .carrier(carrier),
		.pwm_out(pwm_out), .phase(phase), .bpp_mode(bpp_mode),
		.duty(duty), .rx_byte(rx_byte), .rx_valid(rx_valid));

	// 20 MHz clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic cmp(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_phase(input logic [4:0] p, input int lim);
		int n;
		n = 0;
		while (phase !== p && n < lim) begin
			@(negedge clock);
			n++;
		end
		cmp("phase", {3'h0, p}, {3'h0, phase});
	endtask

	// leaves reset asserted so the caller can look at reset values
	task automatic do_reset(input logic [2:0] cls, input logic v5);
		@(negedge clock);
		rst_n = 1'b0;
		src_class = cls;
		src_5v_only = v5;
		repeat (10) @(negedge clock);
	endtask

	task automatic pwm_chk(input logic [7:0] exp);
		int n;
		n = 0;
		repeat (256) begin
			@(negedge clock);
			n += pwm_out;
		end
		cmp("pwm high", exp, n[7:0]);
	endtask

	task automatic t_classes();
		logic [2:0] cs [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h2};
		logic [4:0] eb = 5'h13;
		for (int i = 0; i < 5; i++) begin
			do_reset(cs[i], i == 4);
			cmp("measure", 8'h01, {7'h00, measure_en});
			cmp("power", 8'h00, {7'h00, power_en});
			cmp("duty", 8'h40, duty);
			rst_n = 1'b1;
			repeat (3) @(negedge clock);
			cmp("bpp", {7'h00, eb[i]}, {7'h00, bpp_mode});
			cmp("phase", 8'h02, {3'h0, phase});
			cmp("power", 8'h01, {7'h00, power_en});
		end
		$display("test classes done");
	endtask

	task automatic t_contract();
		do_reset(3'h2, 1'b0);
		rst_n = 1'b1;
		object_seen = 1'b1;
		rx.send_pkt(wpt_pkg::HDR_SIG, 8'h80);
		wait_phase(5'h04, 100);
		cmp("power", 8'h01, {7'h00, power_en});
		cmp("rx byte", 8'h80, rx_byte);
		rx.send_pkt(wpt_pkg::HDR_CFG, 8'h00);
		wait_phase(5'h08, 100);
		$display("test contract done");
	endtask

	// raise, received power report, lower, hold
	task automatic t_power();
		logic [7:0] hd [4] = '{8'h03, 8'h04, 8'h03, 8'h03};
		logic [7:0] pl [4] = '{8'h01, 8'h10, 8'hfc, 8'h00};
		logic [7:0] ex [4] = '{8'h44, 8'h44, 8'h40, 8'h40};
		for (int i = 0; i < 4; i++) begin
			rx.send_pkt(hd[i], pl[i]);
			cmp("duty", ex[i], duty);
			cmp("phase", 8'h08, {3'h0, phase});
			if (i == 0) begin
				pwm_chk(8'h44);
			end
		end
		$display("test power done");
	endtask

	task automatic t_end();
		rx.send_pkt(wpt_pkg::HDR_EPT, 8'h00);
		cmp("phase", 8'h02, {3'h0, phase});
		cmp("duty", 8'h40, duty);
		$display("test end done");
	endtask

	task automatic t_fault();
		fault = 1'b1;
		@(negedge clock);
		cmp("phase", 8'h10, {3'h0, phase});
		@(negedge clock);
		cmp("phase", 8'h01, {3'h0, phase});
		fault = 1'b0;
		wait_phase(5'h02, 400);
		$display("test fault done");
	endtask

	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		rst_n = 1'b0;
		object_seen = 1'b0;
		fault = 1'b0;
		src_class = 3'h0;
		src_5v_only = 1'b0;
		t_classes();
		t_contract();
		t_power();
		t_end();
		t_fault();
		complete_run();
	end

	// watchdog sized from about 1.7 million cycles of packets
	initial begin
		repeat (2500000) @(posedge clock);
		fails++;
		complete_run();
	end
endmodule
